/* bgcd_pkg.sv */
`default_nettype none
package bgcd_pkg;

    // Clock and times
    localparam longint unsigned CLK_HZ        = 64'd10_000_000;
    localparam longint unsigned SLOT_SHORT_US = 64'd500;
    localparam longint unsigned SLOT_LONG_US  = 64'd2000;
    localparam longint unsigned WDG_PERIOD_S  = 64'd100;
    localparam int unsigned SLOT_SHORT_CYC =
        int'(SLOT_SHORT_US * CLK_HZ / 64'd1_000_000);
    localparam int unsigned SLOT_LONG_CYC =
        int'(SLOT_LONG_US * CLK_HZ / 64'd1_000_000);
    localparam int unsigned WDG_PERIOD_CYC = int'(WDG_PERIOD_S * CLK_HZ);

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFF_WDG_KICK = 8'h10;

    // Configuration word bit positions
    localparam int CFG_W            = 22;
    localparam int B_RTC_FULL       = 0;
    localparam int B_CLK_SRC        = 1;
    localparam int B_KEEP_ON        = 2;
    localparam int B_SLOT_DUR       = 3;
    localparam int B_LP_OFF         = 4;
    localparam int B_LP_RST         = 5;
    localparam int B_IRQ_POL        = 6;
    localparam int B_SUPPLY_MSK     = 7;
    localparam int B_L5_FALL_MSK    = 8;
    localparam int B_L5_RISE_MSK    = 9;
    localparam int B_L4_FALL_MSK    = 10;
    localparam int B_L4_RISE_MSK    = 11;
    localparam int B_L0_OD          = 12;
    localparam int B_WDG_EN         = 13;
    localparam int B_DIV_BYPASS     = 14;
    localparam int B_THRESH_LO      = 15;
    localparam int B_AUTO_KEEP      = 20;
    localparam int B_PDR_POL        = 21;

    // Interrupt status layout; bits 0..4 share the config mask bits
    localparam int IRQ_W            = 9;
    localparam int I_SUPPLY         = 0;
    localparam int I_L5_FALL        = 1;
    localparam int I_L5_RISE        = 2;
    localparam int I_L4_FALL        = 3;
    localparam int I_L4_RISE        = 4;
    localparam int I_HOLD_RISE      = 5;
    localparam int I_HOLD_FALL      = 6;
    localparam int I_WDG            = 7;
    localparam int I_BUTTON         = 8;
    localparam logic [3:0] MASK_HI_RST = 4'h0;

    // Threshold code for 3.1 V
    localparam logic [4:0] THRESH_FIXED = 5'h0C;

    // Fixed boot defaults, MSB first
    localparam logic [CFG_W-1:0] CFG_FIXED = {
        1'b0, 1'b1, THRESH_FIXED, 1'b1, 1'b1, 1'b0,
        1'b0, 1'b1, 1'b0, 1'b1, 1'b1,
        1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0
    };

    typedef enum logic [1:0] {
        BGCD_BOOT_FIXED,
        BGCD_BOOT_NVM,
        BGCD_BOOT_TEST
    } bgcd_boot_t;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

/* bgcd_loader.sv */
// How it works
// - RTC supply bit: 0 low power in OFF, 1 full power; fixed 0
// - Slow clock select: 0 crystal or external, 1 internal RC; fixed 0
// - Keep-on bit 1 holds device powered; 0 does nothing; fixed 0
// - Slot duration: 0 gives 0.5 ms, 1 gives 2 ms; fixed 2 ms
// - Long-press-off bit 1 lets a long press turn device off; fixed 1
// - Long-press reset bit 1 resets digital core while off; fixed 1
// - Interrupt polarity: 0 active low, 1 active high; fixed low
// - Supply-insert mask 0 auto switches on at insertion; fixed 1
// - Line 4/5 edge masks block their interrupt; falls masked, rises not
// - Line 0 output: 0 push-pull, 1 open drain; fixed push-pull
// - Watchdog bit: 0 off, 1 periodic with 100 s period; fixed 1
// - Divider buffer bypass: 0 buffer on, 1 buffer off; fixed off
// - Five-bit threshold picks boot comparator level; fixed 3.1 V
// - Auto-keep-on 1 makes hold pin a plain input, sets keep-on
// - Power-down reset polarity: 0 active low, 1 active high
// - Boot pin sampled at power-up: float test, low fixed, high memory
// - Fixed boot uses constant defaults; memory boot uses stored word
`timescale 1ns/10ps
`default_nettype none
module bgcd_loader #(
    parameter int unsigned SLOT_SHORT_CYC = bgcd_pkg::SLOT_SHORT_CYC,
    parameter int unsigned SLOT_LONG_CYC  = bgcd_pkg::SLOT_LONG_CYC,
    parameter int unsigned WDG_CYC        = bgcd_pkg::WDG_PERIOD_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        boot_select_pin,
    input  wire logic        boot_select_float,
    output var  logic        nvm_rd_req,
    input  wire logic        nvm_rd_valid,
    input  wire logic [31:0] nvm_rd_data,
    output var  logic        load_done,
    output var  logic        test_boot,
    input  wire logic        seq_run,
    output var  logic        slot_tick,
    output var  logic        rtc_supply_off_full_power,
    output var  logic        slow_clock_source_sel,
    output var  logic        keep_on,
    output var  logic        slot_duration_sel,
    input  wire logic        hold_pin,
    input  wire logic        reset_out_high,
    output var  logic        power_hold_req,
    input  wire logic        button_in_long,
    input  wire logic        button_in_low,
    input  wire logic        device_off,
    output var  logic        power_off_req,
    output var  logic        core_reset_req,
    input  wire logic        supply_insert_evt,
    output var  logic        auto_switch_on,
    input  wire logic        line4_in,
    input  wire logic        line5_in,
    input  wire logic        line0_data,
    output var  logic        line0_out,
    output var  logic        line0_oe_n,
    output var  logic        wdg_expire,
    output var  logic        divider_buffer_en,
    output var  logic [4:0]  boot_gate_threshold,
    input  wire logic        power_init_reset_in,
    output var  logic        power_init_reset_act,
    output var  logic        irq_out
);

    localparam int CW = bgcd_pkg::CFG_W;
    localparam int IW = bgcd_pkg::IRQ_W;

    typedef enum logic [1:0] {
        ST_SAMPLE,
        ST_NVM_WAIT,
        ST_DONE
    } bgcd_state_t;

    function automatic logic [31:0] bgcd_strb(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    bgcd_state_t          state_q;
    bgcd_pkg::bgcd_boot_t mode_q;
    logic [CW-1:0]        cfg_q;
    logic [3:0]           mask_hi_q;
    logic [IW-1:0]        irq_stat_q;
    logic [IW-1:0]        irq_set;
    logic [IW-1:0]        irq_mask;
    logic                 aw_held_q;
    logic                 w_held_q;
    logic [7:0]           aw_addr_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic [31:0]          rd_word;
    logic                 rd_ok;
    logic [31:0]          cfg_wr;
    logic [31:0]          mask_wr;
    logic [31:0]          clr_wr;
    logic                 l4_q;
    logic                 l5_q;
    logic                 hold_q;
    logic                 rst_out_q;
    logic                 seq_run_q;
    logic [31:0]          slot_cnt_q;
    logic [31:0]          slot_len;
    logic [31:0]          wdg_cnt_q;
    logic                 wdg_hit;
    logic                 wdg_kick;
    logic                 keep_set;

    assign irq_mask = {mask_hi_q, cfg_q[bgcd_pkg::B_L4_RISE_MSK:
                                         bgcd_pkg::B_SUPPLY_MSK]};

    // Boot source selection and load sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_SAMPLE;
            mode_q  <= bgcd_pkg::BGCD_BOOT_FIXED;
        end else begin
            case (state_q)
                ST_SAMPLE: begin
                    if (boot_select_float) begin
                        mode_q  <= bgcd_pkg::BGCD_BOOT_TEST;
                        state_q <= ST_DONE;
                    end else if (boot_select_pin) begin
                        mode_q  <= bgcd_pkg::BGCD_BOOT_NVM;
                        state_q <= ST_NVM_WAIT;
                    end else begin
                        mode_q  <= bgcd_pkg::BGCD_BOOT_FIXED;
                        state_q <= ST_DONE;
                    end
                end
                ST_NVM_WAIT: begin
                    if (nvm_rd_valid) begin
                        state_q <= ST_DONE;
                    end
                end
                default: begin
                    state_q <= ST_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nvm_rd_req <= 1'b0;
            load_done  <= 1'b0;
            test_boot  <= 1'b0;
        end else begin
            nvm_rd_req <= (state_q == ST_SAMPLE && !boot_select_float &&
                           boot_select_pin) ||
                          (state_q == ST_NVM_WAIT && !nvm_rd_valid);
            load_done  <= (state_q == ST_DONE);
            test_boot  <= (mode_q == bgcd_pkg::BGCD_BOOT_TEST);
        end
    end

    // AXI4-Lite write side; address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= bgcd_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (!aw_held_q && !s_axi_awready && s_axi_awvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (!w_held_q && !s_axi_wready && s_axi_wvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (aw_held_q && w_held_q && !s_axi_bvalid) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_q == bgcd_pkg::OFF_CTRL ||
                    aw_addr_q == bgcd_pkg::OFF_IRQ_STAT ||
                    aw_addr_q == bgcd_pkg::OFF_IRQ_MASK ||
                    aw_addr_q == bgcd_pkg::OFF_WDG_KICK) begin
                    s_axi_bresp <= bgcd_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= bgcd_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Commit strobe: both halves held, response not yet raised
    logic commit;
    assign commit = aw_held_q && w_held_q && !s_axi_bvalid;

    assign cfg_wr  = bgcd_strb({{(32-CW){1'b0}}, cfg_q}, w_data_q, w_strb_q);
    assign mask_wr = bgcd_strb({{(32-IW){1'b0}}, irq_mask}, w_data_q,
                               w_strb_q);
    assign clr_wr  = bgcd_strb(32'h0000_0000, w_data_q, w_strb_q);
    assign wdg_kick = commit && aw_addr_q == bgcd_pkg::OFF_WDG_KICK &&
                      clr_wr[0];

    // Keep-on is raised internally on the reset output rising edge
    assign keep_set = cfg_q[bgcd_pkg::B_AUTO_KEEP] && reset_out_high &&
                      !rst_out_q;

    // Configuration bits: loaded once, then owned by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q     <= bgcd_pkg::CFG_FIXED;
            mask_hi_q <= bgcd_pkg::MASK_HI_RST;
        end else begin
            if (state_q == ST_NVM_WAIT && nvm_rd_valid) begin
                cfg_q <= nvm_rd_data[CW-1:0];
            end else if (state_q == ST_SAMPLE) begin
                cfg_q <= bgcd_pkg::CFG_FIXED;
            end else if (state_q == ST_DONE && commit &&
                         aw_addr_q == bgcd_pkg::OFF_CTRL) begin
                cfg_q <= cfg_wr[CW-1:0];
            end else if (state_q == ST_DONE && commit &&
                         aw_addr_q == bgcd_pkg::OFF_IRQ_MASK) begin
                cfg_q[bgcd_pkg::B_L4_RISE_MSK:bgcd_pkg::B_SUPPLY_MSK] <=
                    mask_wr[4:0];
                mask_hi_q <= mask_wr[IW-1:5];
            end
            if (state_q == ST_DONE && keep_set) begin
                cfg_q[bgcd_pkg::B_KEEP_ON] <= 1'b1;
            end
        end
    end

    // AXI4-Lite read side, answer raised in the same cycle the address is taken
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        if (s_axi_araddr == bgcd_pkg::OFF_CTRL) begin
            rd_word[CW-1:0] = cfg_q;
        end else if (s_axi_araddr == bgcd_pkg::OFF_STATUS) begin
            rd_word[0]   = (state_q == ST_DONE);
            rd_word[2:1] = mode_q;
            rd_word[3]   = hold_q;
            rd_word[4]   = power_hold_req;
        end else if (s_axi_araddr == bgcd_pkg::OFF_IRQ_STAT) begin
            rd_word[IW-1:0] = irq_stat_q;
        end else if (s_axi_araddr == bgcd_pkg::OFF_IRQ_MASK) begin
            rd_word[IW-1:0] = irq_mask;
        end else if (s_axi_araddr == bgcd_pkg::OFF_WDG_KICK) begin
            rd_word = 32'h0000_0000;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= bgcd_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid && !s_axi_arready &&
                         s_axi_arvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_ok ? bgcd_pkg::RESP_OKAY :
                                         bgcd_pkg::RESP_SLVERR;
            end
        end
    end

    // Edge history of the monitored inputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            l4_q      <= 1'b0;
            l5_q      <= 1'b0;
            hold_q    <= 1'b0;
            rst_out_q <= 1'b0;
            seq_run_q <= 1'b0;
        end else begin
            l4_q      <= line4_in;
            l5_q      <= line5_in;
            hold_q    <= hold_pin;
            rst_out_q <= reset_out_high;
            seq_run_q <= seq_run;
        end
    end

    always_comb begin
        irq_set = '0;
        irq_set[bgcd_pkg::I_SUPPLY]  = supply_insert_evt;
        irq_set[bgcd_pkg::I_L5_FALL] = l5_q && !line5_in;
        irq_set[bgcd_pkg::I_L5_RISE] = !l5_q && line5_in;
        irq_set[bgcd_pkg::I_L4_FALL] = l4_q && !line4_in;
        irq_set[bgcd_pkg::I_L4_RISE] = !l4_q && line4_in;
        irq_set[bgcd_pkg::I_HOLD_RISE] = cfg_q[bgcd_pkg::B_AUTO_KEEP] &&
                                         !hold_q && hold_pin;
        irq_set[bgcd_pkg::I_HOLD_FALL] = cfg_q[bgcd_pkg::B_AUTO_KEEP] &&
                                         hold_q && !hold_pin;
        irq_set[bgcd_pkg::I_WDG]    = wdg_hit;
        irq_set[bgcd_pkg::I_BUTTON] = button_in_low && !device_off;
    end

    // Sticky status; a new event beats a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
        end else if (commit && aw_addr_q == bgcd_pkg::OFF_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~clr_wr[IW-1:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    // Interrupt output with selectable polarity
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_out <= 1'b1;
        end else begin
            irq_out <= cfg_q[bgcd_pkg::B_IRQ_POL] ~^
                       (|(irq_stat_q & ~irq_mask));
        end
    end

    // Slot timer, only once loading is complete
    assign slot_len = cfg_q[bgcd_pkg::B_SLOT_DUR] ?
                      SLOT_LONG_CYC : SLOT_SHORT_CYC;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_cnt_q <= 32'h0000_0000;
            slot_tick  <= 1'b0;
        end else begin
            slot_tick <= 1'b0;
            if (state_q != ST_DONE || !seq_run || !seq_run_q) begin
                slot_cnt_q <= 32'h0000_0000;
            end else if (slot_cnt_q >= slot_len - 32'd1) begin
                slot_cnt_q <= 32'h0000_0000;
                slot_tick  <= 1'b1;
            end else begin
                slot_cnt_q <= slot_cnt_q + 32'd1;
            end
        end
    end

    // Periodic watchdog, restarted by a kick
    assign wdg_hit = cfg_q[bgcd_pkg::B_WDG_EN] && state_q == ST_DONE &&
                     wdg_cnt_q >= WDG_CYC - 32'd1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdg_cnt_q  <= 32'h0000_0000;
            wdg_expire <= 1'b0;
        end else begin
            wdg_expire <= wdg_hit;
            if (!cfg_q[bgcd_pkg::B_WDG_EN] || state_q != ST_DONE ||
                wdg_kick || wdg_hit) begin
                wdg_cnt_q <= 32'h0000_0000;
            end else begin
                wdg_cnt_q <= wdg_cnt_q + 32'd1;
            end
        end
    end

    // Bits that feed the power blocks, registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rtc_supply_off_full_power <= 1'b0;
            slow_clock_source_sel     <= 1'b0;
            keep_on                   <= 1'b0;
            slot_duration_sel         <= 1'b1;
            divider_buffer_en         <= 1'b0;
            boot_gate_threshold       <= bgcd_pkg::THRESH_FIXED;
            power_hold_req            <= 1'b0;
        end else begin
            rtc_supply_off_full_power <= cfg_q[bgcd_pkg::B_RTC_FULL];
            slow_clock_source_sel <= cfg_q[bgcd_pkg::B_CLK_SRC];
            keep_on               <= cfg_q[bgcd_pkg::B_KEEP_ON];
            slot_duration_sel     <= cfg_q[bgcd_pkg::B_SLOT_DUR];
            divider_buffer_en <= !cfg_q[bgcd_pkg::B_DIV_BYPASS];
            boot_gate_threshold <= cfg_q[bgcd_pkg::B_THRESH_LO +: 5];
            power_hold_req <= cfg_q[bgcd_pkg::B_KEEP_ON] ||
                              (!cfg_q[bgcd_pkg::B_AUTO_KEEP] && hold_pin);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_off_req        <= 1'b0;
            core_reset_req       <= 1'b0;
            auto_switch_on       <= 1'b0;
            power_init_reset_act <= 1'b0;
        end else begin
            power_off_req <= button_in_long && !device_off &&
                             cfg_q[bgcd_pkg::B_LP_OFF];
            core_reset_req <= button_in_long && device_off &&
                              cfg_q[bgcd_pkg::B_LP_RST];
            auto_switch_on <= supply_insert_evt &&
                              !cfg_q[bgcd_pkg::B_SUPPLY_MSK];
            power_init_reset_act <= cfg_q[bgcd_pkg::B_PDR_POL] ~^
                                    power_init_reset_in;
        end
    end

    // Line 0 driver; enable low means driving
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line0_out  <= 1'b0;
            line0_oe_n <= 1'b0;
        end else begin
            line0_out  <= line0_data;
            line0_oe_n <= cfg_q[bgcd_pkg::B_L0_OD] && line0_data;
        end
    end

endmodule // bgcd_loader
`default_nettype wire

/* bgcd_nvm_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bgcd_nvm_model #(
    parameter int unsigned DLY  = 3,
    parameter logic [31:0] WORD = 32'h0
) (
    input  wire logic        aclk,
    input  wire logic        rd_req,
    output wire logic        rd_valid,
    output wire logic [31:0] rd_data
);
    int unsigned n = 0;
    logic        v = 1'b0;
    logic [31:0] d = 32'h0;
    assign rd_valid = v;
    assign rd_data  = d;
    always_ff @(posedge aclk) begin
        n <= (rd_req && !v) ? n + 1 : 0;
        v <= rd_req && !v && n == DLY;
        d <= (rd_req && !v && n == DLY) ? WORD : ~d;
    end
endmodule // bgcd_nvm_model
`default_nettype wire

/* bgcd_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module bgcd_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic nvm_rd_req,
    input wire logic nvm_rd_valid,
    input wire logic load_done,
    input wire logic test_boot,
    input wire logic supply_insert_evt,
    input wire logic auto_switch_on,
    input wire logic button_in_long,
    input wire logic device_off,
    input wire logic power_off_req,
    input wire logic core_reset_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_req_held: assert property (
        nvm_rd_req && !nvm_rd_valid |=> nvm_rd_req) else $error("req fell");
    a_load_after_word: assert property (
        nvm_rd_req && nvm_rd_valid |-> ##[1:3] load_done) else $error("no done");
    a_done_kept: assert property (
        load_done |=> load_done) else $error("done fell");
    a_no_req_done: assert property (
        load_done |-> !nvm_rd_req) else $error("req after done");
    a_test_no_read: assert property (
        test_boot |-> !nvm_rd_req) else $error("test boot reads");
    a_insert_on: assert property (
        auto_switch_on |-> $past(supply_insert_evt)) else $error("bad on");
    a_lp_off: assert property (
        power_off_req |-> $past(button_in_long && !device_off))
        else $error("bad off");
    a_lp_reset: assert property (
        core_reset_req |-> $past(button_in_long && device_off))
        else $error("bad reset");
endmodule // bgcd_chk
bind bgcd_loader bgcd_chk u_chk (.*);
`default_nettype wire

/* bgcd_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [31:0] WORD = 32'h0008_3A4D;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, boot_select_pin, boot_select_float;
    logic nvm_rd_valid, seq_run, hold_pin, reset_out_high, button_in_long;
    logic button_in_low, device_off, supply_insert_evt, line4_in, line5_in;
    logic line0_data, power_init_reset_in, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, nvm_rd_req, load_done;
    logic test_boot, slot_tick, rtc_supply_off_full_power, keep_on, irq_out;
    logic slow_clock_source_sel, slot_duration_sel, power_hold_req;
    logic power_off_req, core_reset_req, auto_switch_on, line0_out;
    logic line0_oe_n, wdg_expire, divider_buffer_en, power_init_reset_act;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb;
    logic [4:0] boot_gate_threshold;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, nvm_rd_data;
    int bad_count = 0, checked = 0, cyc = 0;
    wire logic [9:0] outs = {rtc_supply_off_full_power, slow_clock_source_sel,
        keep_on, slot_duration_sel, divider_buffer_en, boot_gate_threshold};
    bgcd_loader #(.SLOT_SHORT_CYC(5), .SLOT_LONG_CYC(20), .WDG_CYC(90000))
        u_dut (.*);
    bgcd_nvm_model #(.DLY(3), .WORD(WORD)) u_nvm (.aclk(aclk),
        .rd_req(nvm_rd_req), .rd_valid(nvm_rd_valid), .rd_data(nvm_rd_data));
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (bad_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [33:0] s, e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("read", {s_axi_rresp, s_axi_rdata}, e);
        @(posedge aclk);
    endtask
    task automatic boot(input logic p, f);
        {aresetn, boot_select_pin, boot_select_float} <= {1'b0, p, f};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        while (load_done !== 1'b1) @(posedge aclk);
        // Pin moves after sampling; button and insert pulses
        {supply_insert_evt, button_in_long, line0_data} <= 3'h7;
        boot_select_pin <= !p;
        @(posedge aclk);
        {supply_insert_evt, device_off} <= 2'h1;
        @(posedge aclk);
        {button_in_long, device_off, line0_data} <= 3'h0;
        repeat (3) @(posedge aclk);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, boot_select_pin, boot_select_float, seq_run, hold_pin,
         reset_out_high, button_in_long, button_in_low, device_off, line4_in,
         supply_insert_evt, line5_in, line0_data, power_init_reset_in} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        boot(1'b0, 1'b0);
        {seq_run, power_init_reset_in} <= 2'h3;
        rd(bgcd_pkg::OFF_CTRL, 34'h0_0016_65B8);
        chk("outs", outs, {5'h02, 5'h0C});
        chk("irq", irq_out, 1'b1);
        chk("pdr", power_init_reset_act, 1'b0);
        line4_in <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("irq", irq_out, 1'b0);
        wr(bgcd_pkg::OFF_IRQ_MASK, 32'h1B);
        chk("irq", irq_out, 1'b1);
        wr(bgcd_pkg::OFF_IRQ_STAT, 32'h11);
        wr(bgcd_pkg::OFF_IRQ_MASK, 32'h0B);
        rd(bgcd_pkg::OFF_IRQ_STAT, 34'h0);
        chk("irq", irq_out, 1'b1);
        rd(8'h14, 34'h2_0000_0000);
        boot(1'b1, 1'b0);
        rd(bgcd_pkg::OFF_CTRL, {12'h0, WORD[21:0]});
        chk("outs", outs, {WORD[0], WORD[1], WORD[2], WORD[3], !WORD[14],
            WORD[19:15]});
        chk("irq", irq_out, 1'b1);
        rd(bgcd_pkg::OFF_STATUS, 34'h13);
        boot(1'b1, 1'b1);
        chk("test", test_boot, 1'b1);
        rd(bgcd_pkg::OFF_CTRL, 34'h0_0016_65B8);
        complete_run();
    end
endmodule // testbench
`default_nettype wire
